/* core/ofr_fifo_dev.sv */
// fifo device end: storage buffer, offset registers, flags and replay
//
// Notes on behaviour
// [RULE_01] load pin low in reset enables offset access
// [RULE_02] offset writes cycle empty low, high, full low, high
// [RULE_03] sequence resumes where it stopped after load rises
// [RULE_04] offset reads follow the same cyclic order
// [RULE_05] host avoids mixed offset access; load-only write idles
// [RULE_06] almost-empty low at or below empty offset
// [RULE_07] almost-empty high above empty offset
// [RULE_08] almost-full low once free space is m or less
// [RULE_09] almost-full high while free space exceeds m
// [RULE_10] full flag low when full, blocks writes
// [RULE_11] empty flag low when empty, blocks reads
// [RULE_12] flag levels at empty and full as tabled
// [RULE_13] unprogrammed offsets default to seven
// [RULE_14] replay rewinds read pointer, non-chained modes only
// [RULE_15] host holds transfers off during and after replay
// [RULE_16] after replay old data then new data flows
// [RULE_17] host replays only after a read, within depth
// [RULE_18] width expansion combines end flags externally
// [RULE_19] depth chain wiring and ORed flags are external
// [RULE_20] load pin level at reset picks chained mode
// [RULE_21] reset restarts both offset sequences at empty low

// =========================================================
// storage buffer
module ofr_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       flush,
  input  wire logic                       rewind,
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output      logic                       in_ready,
  output      logic                       out_valid,
  output      logic [WIDTH-1:0]           out_data,
  input  wire logic                       out_ready,
  output      logic [$clog2(DEPTH):0]     level,
  output      logic [$clog2(DEPTH):0]     wr_fill
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } ofr_buf_state_t;

  ofr_buf_state_t st;
  ofr_buf_state_t next_st;

  assign level     = st.wr - st.rd;
  assign wr_fill   = st.wr;
  assign in_ready  = level != (AW+1)'(DEPTH);
  assign out_valid = st.wr != st.rd;
  assign out_data  = st.mem[st.rd[AW-1:0]];

  always_comb
  begin
    next_st = st;
    if (flush)
    begin
      next_st.wr = '0;
      next_st.rd = '0;
    end
    else if (rewind)
    begin
      // wr counts from the last reset, so it is also the refill level
      next_st.rd = '0; // [RULE_14]
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        next_st.mem[st.wr[AW-1:0]] = in_data;
        next_st.wr                 = st.wr + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        next_st.rd = st.rd + 1'b1; // [RULE_16]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

// =========================================================
// device end
module ofr_fifo_dev
  import ofr_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  ofr_link_if.dev               link,
  output      logic             depth_mode,
  output      logic [CNT_W-1:0] occupancy
);
  ofr_dev_state_t    st;
  ofr_dev_state_t    next_st;
  logic              prog;
  logic              push;
  logic              pop;
  logic              flush;
  logic              rewind;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [WORD_W-1:0] buf_out_data;
  logic [CNT_W-1:0]  buf_level;
  logic [CNT_W-1:0]  buf_wr_fill;
  logic [CNT_W-1:0]  cnt;
  logic [OFFS_W-1:0] n_offs;
  logic [OFFS_W-1:0] m_offs;

  ofr_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .flush     (flush),
    .rewind    (rewind),
    .in_valid  (push),
    .in_data   (link.data_in),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (pop),
    .level     (buf_level),
    .wr_fill   (buf_wr_fill)
  );

  assign link.data_out            = st.q;
  assign link.full_flag_n         = st.ff_n;
  assign link.empty_flag_n        = st.ef_n;
  assign link.almost_empty_flag_n = st.pae_n;
  assign link.almost_full_flag_n  = st.paf_n;
  assign link.chain_token_out_n   = 1'b1;
  assign depth_mode               = st.mode_depth;
  assign occupancy                = st.level;

  assign n_offs = ofr_join(st.offs[SEL_EMPTY_HIGH], st.offs[SEL_EMPTY_LOW]);
  assign m_offs = ofr_join(st.offs[SEL_FULL_HIGH], st.offs[SEL_FULL_LOW]);

  always_comb
  begin
    next_st = st;
    push    = 1'b0;
    pop     = 1'b0;
    flush   = 1'b0;
    rewind  = 1'b0;
    cnt     = buf_level;
    prog    = !st.mode_depth && !link.load_enable_n; // [RULE_01]
    if (!link.master_reset_n)
    begin
      next_st.mode_depth           = link.load_enable_n; // [RULE_20] [RULE_01]
      next_st.wr_sel               = SEL_EMPTY_LOW; // [RULE_21]
      next_st.rd_sel               = SEL_EMPTY_LOW; // [RULE_21]
      next_st.offs[SEL_EMPTY_LOW]  = OFFS_DEFAULT_LOW; // [RULE_13]
      next_st.offs[SEL_EMPTY_HIGH] = OFFS_DEFAULT_HIGH; // [RULE_13]
      next_st.offs[SEL_FULL_LOW]   = OFFS_DEFAULT_LOW; // [RULE_13]
      next_st.offs[SEL_FULL_HIGH]  = OFFS_DEFAULT_HIGH; // [RULE_13]
      next_st.q                    = DATA_RESET;
      flush                        = 1'b1;
      cnt                          = '0;
    end
    else
    begin
      if (prog)
      begin
        // load low with write and read both high is a no-op
        if (!link.wr_en_n)
        begin
          next_st.offs[st.wr_sel] = link.data_in; // [RULE_02]
          next_st.wr_sel          = st.wr_sel + 2'h1; // [RULE_02] [RULE_03]
        end
        if (!link.rd_en_n)
        begin
          next_st.q      = st.offs[st.rd_sel]; // [RULE_04]
          next_st.rd_sel = st.rd_sel + 2'h1; // [RULE_04] [RULE_03]
        end
      end
      else
      begin
        push = !link.wr_en_n && st.ff_n && buf_in_ready; // [RULE_10]
        pop  = !link.rd_en_n && st.ef_n && buf_out_valid; // [RULE_11]
        if (pop)
        begin
          next_st.q = buf_out_data; // [RULE_16]
        end
      end
      // transfers are held off by the host around replay, so none are lost here
      rewind = link.replay_pulse && !st.mode_depth; // [RULE_14]
      if (rewind)
      begin
        cnt  = buf_wr_fill; // [RULE_16]
        push = 1'b0;
        pop  = 1'b0;
      end
      else
      begin
        cnt = buf_level + CNT_W'(push) - CNT_W'(pop);
      end
    end
    // flags look at the occupancy after this edge, so they never lag a transfer
    next_st.level = cnt;
    next_st.ef_n  = cnt != '0; // [RULE_11] [RULE_12]
    next_st.ff_n  = cnt != CNT_W'(FIFO_DEPTH); // [RULE_10] [RULE_12]
    next_st.pae_n = ofr_above(cnt, n_offs); // [RULE_06] [RULE_07] [RULE_12]
    next_st.paf_n = ofr_above(CNT_W'(FIFO_DEPTH) - cnt, m_offs); // [RULE_08] [RULE_09] [RULE_12]
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st                    <= '0;
      st.offs[SEL_FULL_LOW] <= OFFS_DEFAULT_LOW;
      st.offs[SEL_EMPTY_LOW] <= OFFS_DEFAULT_LOW;
      st.ff_n               <= 1'b1;
      st.paf_n              <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

/* core/ofr_pkg.sv */
// shared constants, types and helpers for the offset-flag fifo pair
package ofr_pkg;

  // =========================================================
  // widths and depth
  localparam int WORD_W     = 9;
  localparam int OFFS_W     = 18;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 5;

  // =========================================================
  // offset register sequence and defaults
  localparam logic [1:0]        SEL_EMPTY_LOW     = 2'h0;
  localparam logic [1:0]        SEL_EMPTY_HIGH    = 2'h1;
  localparam logic [1:0]        SEL_FULL_LOW      = 2'h2;
  localparam logic [1:0]        SEL_FULL_HIGH     = 2'h3;
  localparam logic [WORD_W-1:0] OFFS_DEFAULT_LOW  = 9'h007;
  localparam logic [WORD_W-1:0] OFFS_DEFAULT_HIGH = 9'h000;
  localparam logic [WORD_W-1:0] DATA_RESET        = 9'h000;

  // =========================================================
  // timing, one ref_clk period is 100 ns
  localparam int CLK_NS             = 100;
  localparam int MRESET_NS          = 10;
  localparam int REPLAY_PULSE_NS    = 60;
  localparam int REPLAY_RECOVERY_NS = 90;
  localparam int MRESET_CYC         = (MRESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int REPLAY_PULSE_CYC   = (REPLAY_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REPLAY_RECOVER_CYC = (REPLAY_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] TIMER_ONE  = 4'h1;

  // =========================================================
  // host commands
  typedef enum logic [2:0] {
    CMD_WRITE,
    CMD_READ,
    CMD_LOAD,
    CMD_PEEK,
    CMD_REPLAY,
    CMD_RESET
  } ofr_cmd_t;

  // =========================================================
  // device state
  typedef struct packed {
    logic                   mode_depth;
    logic [1:0]             wr_sel;
    logic [1:0]             rd_sel;
    logic [3:0][WORD_W-1:0] offs;
    logic [WORD_W-1:0]      q;
    logic                   ff_n;
    logic                   ef_n;
    logic                   pae_n;
    logic                   paf_n;
    logic [CNT_W-1:0]       level;
  } ofr_dev_state_t;

  function automatic logic [OFFS_W-1:0] ofr_join(input logic [WORD_W-1:0] hi, input logic [WORD_W-1:0] lo);
    ofr_join = {hi, lo};
  endfunction

  function automatic logic ofr_above(input logic [CNT_W-1:0] cnt, input logic [OFFS_W-1:0] offs);
    ofr_above = OFFS_W'(cnt) > offs;
  endfunction

  function automatic logic [3:0] ofr_cycles(input int cyc);
    ofr_cycles = (cyc < 1) ? TIMER_ONE : 4'(cyc);
  endfunction

endpackage

/* core/ofr_link_if.sv */
// pin-level link between the fifo device and its host
interface ofr_link_if;
  import ofr_pkg::*;
  logic              master_reset_n;
  logic              wr_en_n;
  logic              rd_en_n;
  logic              load_enable_n;
  logic              replay_pulse;
  logic              first_device_select_n;
  logic [WORD_W-1:0] data_in;
  logic [WORD_W-1:0] data_out;
  logic              full_flag_n;
  logic              empty_flag_n;
  logic              almost_empty_flag_n;
  logic              almost_full_flag_n;
  logic              chain_token_out_n;

  modport dev (
    input  master_reset_n, wr_en_n, rd_en_n, load_enable_n, replay_pulse, first_device_select_n, data_in,
    output data_out, full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n, chain_token_out_n
  );
  modport host (
    output master_reset_n, wr_en_n, rd_en_n, load_enable_n, replay_pulse, first_device_select_n, data_in,
    input  data_out, full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n, chain_token_out_n
  );
endinterface

/* core/ofr_fifo_host.sv */
// host end: turns user commands into pin cycles on the fifo link
module ofr_fifo_host
  import ofr_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  ofr_link_if.host               link,
  input  wire logic              cmd_valid,
  input  wire ofr_cmd_t          cmd_op,
  input  wire logic [WORD_W-1:0] cmd_data,
  output      logic              cmd_ready,
  output      logic              rsp_valid,
  output      logic [WORD_W-1:0] rsp_data,
  output      logic              rsp_error,
  output      logic [3:0]        status
);
  typedef enum logic [1:0] {
    H_IDLE,
    H_DRIVE,
    H_SETTLE
  } ofr_phase_t;

  typedef struct packed {
    ofr_phase_t        phase;
    ofr_cmd_t          op;
    logic [3:0]        timer;
    logic              mrst_n;
    logic              wr_n;
    logic              rd_n;
    logic              ld_n;
    logic              replay;
    logic [WORD_W-1:0] dout;
    logic              ready;
    logic              rvalid;
    logic [WORD_W-1:0] rdata;
    logic              rerr;
    logic [3:0]        flags;
    logic [CNT_W:0]    writes;
    logic              read_seen;
  } ofr_host_state_t;

  ofr_host_state_t st;
  ofr_host_state_t next_st;

  assign link.master_reset_n        = st.mrst_n;
  assign link.wr_en_n               = st.wr_n;
  assign link.rd_en_n               = st.rd_n;
  assign link.load_enable_n         = st.ld_n;
  assign link.replay_pulse          = st.replay;
  assign link.data_in               = st.dout;
  assign link.first_device_select_n = 1'b0; // [RULE_19]
  assign cmd_ready                  = st.ready;
  assign rsp_valid                  = st.rvalid;
  assign rsp_data                   = st.rdata;
  assign rsp_error                  = st.rerr;
  // lone device, so its own end flags are the composite ones
  assign status                     = st.flags; // [RULE_18]

  always_comb
  begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    next_st.flags  = {link.full_flag_n, link.almost_full_flag_n, link.almost_empty_flag_n, link.empty_flag_n};
    case (st.phase)
      H_IDLE:
      begin
        if (cmd_valid)
        begin
          next_st.op    = cmd_op;
          next_st.dout  = cmd_data;
          next_st.timer = TIMER_ONE;
          next_st.rerr  = 1'b0;
          next_st.phase = H_DRIVE;
          case (cmd_op)
            CMD_WRITE:
            begin
              next_st.wr_n = 1'b0;
              next_st.rerr = !link.full_flag_n;
              if (link.full_flag_n && st.writes <= (CNT_W+1)'(FIFO_DEPTH))
              begin
                next_st.writes = st.writes + 1'b1;
              end
            end
            CMD_READ:
            begin
              next_st.rd_n      = 1'b0;
              next_st.rerr      = !link.empty_flag_n;
              next_st.read_seen = st.read_seen | link.empty_flag_n;
            end
            CMD_LOAD:
            begin
              // write only, never with a read in the same cycle
              next_st.ld_n = 1'b0; // [RULE_05]
              next_st.wr_n = 1'b0;
            end
            CMD_PEEK:
            begin
              next_st.ld_n = 1'b0; // [RULE_05]
              next_st.rd_n = 1'b0;
            end
            CMD_REPLAY:
            begin
              if (st.read_seen && st.writes <= (CNT_W+1)'(FIFO_DEPTH)) // [RULE_17]
              begin
                next_st.replay = 1'b1;
                next_st.timer  = ofr_cycles(REPLAY_PULSE_CYC);
              end
              else
              begin
                next_st.rerr   = 1'b1;
                next_st.rvalid = 1'b1;
                next_st.phase  = H_IDLE;
              end
            end
            CMD_RESET:
            begin
              next_st.mrst_n    = 1'b0;
              next_st.ld_n      = cmd_data[0]; // low selects offset access
              next_st.timer     = ofr_cycles(MRESET_CYC);
              next_st.writes    = '0;
              next_st.read_seen = 1'b0;
            end
            default:
            begin
              next_st.rerr   = 1'b1;
              next_st.rvalid = 1'b1;
              next_st.phase  = H_IDLE;
            end
          endcase
        end
      end
      H_DRIVE:
      begin
        next_st.timer = st.timer - 4'h1;
        if (st.timer == TIMER_ONE)
        begin
          // no transfer pins move while replay recovers
          next_st.mrst_n = 1'b1; // [RULE_15]
          next_st.wr_n   = 1'b1; // [RULE_15]
          next_st.rd_n   = 1'b1; // [RULE_15]
          next_st.ld_n   = 1'b1;
          next_st.replay = 1'b0;
          next_st.timer  = (st.op == CMD_REPLAY) ? ofr_cycles(REPLAY_RECOVER_CYC) : TIMER_ONE;
          next_st.phase  = H_SETTLE;
        end
      end
      H_SETTLE:
      begin
        next_st.timer = st.timer - 4'h1;
        if (st.timer == TIMER_ONE)
        begin
          next_st.rvalid = 1'b1;
          next_st.rdata  = link.data_out;
          next_st.phase  = H_IDLE;
        end
      end
      default:
      begin
        next_st.phase = H_IDLE;
      end
    endcase
    next_st.ready = (next_st.phase == H_IDLE) && !(st.phase == H_IDLE && cmd_valid);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st        <= '0;
      st.phase  <= H_IDLE;
      st.mrst_n <= 1'b1;
      st.wr_n   <= 1'b1;
      st.rd_n   <= 1'b1;
      st.ld_n   <= 1'b1;
      st.flags  <= 4'hC;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

/* verif/ofr_link_properties.sv */
// assertions on the link between fifo device and host
module ofr_link_properties
  import ofr_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              master_reset_n,
  input wire logic              wr_en_n,
  input wire logic              rd_en_n,
  input wire logic              load_enable_n,
  input wire logic              replay_pulse,
  input wire logic [WORD_W-1:0] data_out,
  input wire logic              full_flag_n,
  input wire logic              empty_flag_n,
  input wire logic              almost_empty_flag_n,
  input wire logic              almost_full_flag_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // =========================================================
  // boundary flags
  a_full_blocks_write: assert property (!full_flag_n && rd_en_n && !replay_pulse && master_reset_n |=>
    !full_flag_n) else $error("write accepted while full");
  a_empty_blocks_read: assert property (!empty_flag_n && wr_en_n && load_enable_n && !replay_pulse
    && master_reset_n |=> !empty_flag_n && $stable(data_out)) else $error("read accepted while empty");
  a_write_lifts_empty: assert property (!empty_flag_n && !wr_en_n && load_enable_n && !replay_pulse
    && master_reset_n |=> empty_flag_n) else $error("write into empty fifo lost");
  a_empty_fall_cause: assert property ($fell(empty_flag_n) |->
    !$past(rd_en_n) || $past(replay_pulse) || !$past(master_reset_n)) else $error("empty flag fell without read");
  a_full_state: assert property (!full_flag_n |-> !almost_full_flag_n && empty_flag_n)
    else $error("flag set inconsistent at full");
  a_empty_state: assert property (!empty_flag_n |-> !almost_empty_flag_n && full_flag_n)
    else $error("flag set inconsistent at empty");

  // =========================================================
  // programmable flags and reset
  a_ae_rise_cause: assert property ($rose(almost_empty_flag_n) |-> !$past(wr_en_n) || $past(replay_pulse))
    else $error("almost empty rose without write");
  a_af_fall_cause: assert property ($fell(almost_full_flag_n) |-> !$past(wr_en_n) || $past(replay_pulse))
    else $error("almost full fell without write");
  a_master_reset_state: assert property (!master_reset_n |=> full_flag_n && almost_full_flag_n
    && !almost_empty_flag_n && !empty_flag_n && data_out == DATA_RESET) else $error("master reset state wrong");

  c_full_reached: cover property ($fell(full_flag_n));
  c_replay: cover property (replay_pulse);
  c_offset_read: cover property (!load_enable_n && !rd_en_n);
  c_write_at_full: cover property (!full_flag_n && !wr_en_n);
endmodule

/* verif/testbench.sv */
// self-checking bench for the fifo device and host pair
module testbench
  import ofr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // =========================================================
  // signals
  localparam int WATCH_CYC = 5000; // about 60 commands of three cycles, with wide margin
  typedef struct {ofr_cmd_t op; logic [WORD_W-1:0] din; logic [WORD_W-1:0] dexp; logic eexp; logic [3:0] fexp;} ofr_row_t;
  logic              ref_clk;
  logic              reset_n;
  logic              cmd_valid;
  ofr_cmd_t          cmd_op;
  logic [WORD_W-1:0] cmd_data;
  logic              cmd_ready;
  logic              rsp_valid;
  logic [WORD_W-1:0] rsp_data;
  logic              rsp_error;
  logic [3:0]        status;
  logic              depth_mode;
  logic [CNT_W-1:0]  occupancy;
  logic [WORD_W-1:0] got;
  logic              gerr;
  int                errors;
  int                n_checks;
  int                occ;

  ofr_link_if lnk ();
  ofr_fifo_dev i_ofr_fifo_dev (.ref_clk(ref_clk), .reset_n(reset_n), .link(lnk), .depth_mode(depth_mode),
    .occupancy(occupancy));
  ofr_fifo_host i_ofr_fifo_host (.ref_clk(ref_clk), .reset_n(reset_n), .link(lnk), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .status(status));
  ofr_link_properties i_ofr_link_properties (.ref_clk(ref_clk), .reset_n(reset_n),
    .master_reset_n(lnk.master_reset_n), .wr_en_n(lnk.wr_en_n), .rd_en_n(lnk.rd_en_n),
    .load_enable_n(lnk.load_enable_n), .replay_pulse(lnk.replay_pulse), .data_out(lnk.data_out),
    .full_flag_n(lnk.full_flag_n), .empty_flag_n(lnk.empty_flag_n),
    .almost_empty_flag_n(lnk.almost_empty_flag_n), .almost_full_flag_n(lnk.almost_full_flag_n));

  // offsets n and m as the table leaves them: n=2, m=3
  ofr_row_t rows [20] = '{
    '{CMD_REPLAY, 9'h000, 9'h000, 1'b1, 4'hC},
    '{CMD_READ,   9'h000, 9'h000, 1'b1, 4'hC},
    '{CMD_WRITE,  9'h1A5, 9'h000, 1'b0, 4'hD},
    '{CMD_WRITE,  9'h05A, 9'h000, 1'b0, 4'hD},
    '{CMD_READ,   9'h000, 9'h1A5, 1'b0, 4'hD},
    '{CMD_REPLAY, 9'h000, 9'h000, 1'b0, 4'hD},
    '{CMD_READ,   9'h000, 9'h1A5, 1'b0, 4'hD},
    '{CMD_READ,   9'h000, 9'h05A, 1'b0, 4'hC},
    '{CMD_PEEK,   9'h000, 9'h007, 1'b0, 4'hC},
    '{CMD_PEEK,   9'h000, 9'h000, 1'b0, 4'hC},
    '{CMD_PEEK,   9'h000, 9'h007, 1'b0, 4'hC},
    '{CMD_PEEK,   9'h000, 9'h000, 1'b0, 4'hC},
    '{CMD_LOAD,   9'h001, 9'h000, 1'b0, 4'hC},
    '{CMD_LOAD,   9'h000, 9'h000, 1'b0, 4'hC},
    '{CMD_PEEK,   9'h000, 9'h001, 1'b0, 4'hC},
    '{CMD_LOAD,   9'h003, 9'h000, 1'b0, 4'hC},
    '{CMD_PEEK,   9'h000, 9'h000, 1'b0, 4'hC},
    '{CMD_LOAD,   9'h000, 9'h000, 1'b0, 4'hC},
    '{CMD_LOAD,   9'h002, 9'h000, 1'b0, 4'hC},
    '{CMD_PEEK,   9'h000, 9'h003, 1'b0, 4'hC}
  };

  // =========================================================
  // helpers
  function automatic logic [3:0] xf(int o, int n, int m);
    xf = {o != FIFO_DEPTH, (FIFO_DEPTH - o) > m, o > n, o != 0};
  endfunction

  function automatic logic [3:0] lf();
    lf = {lnk.full_flag_n, lnk.almost_full_flag_n, lnk.almost_empty_flag_n, lnk.empty_flag_n};
  endfunction

  task automatic chk_w(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_f(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_b(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one command, driven for one cycle once ready; bounded waits so a stuck host cannot hang the run
  task automatic do_cmd(input ofr_cmd_t op, input logic [WORD_W-1:0] d);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 20)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = d;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk_b("rsp_valid", 1'b1, rsp_valid);
    got  = rsp_data;
    gerr = rsp_error;
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // =========================================================
  // stimulus
  always #(CLK_NS / 2) ref_clk = ~ref_clk;

  initial
  begin
    #(WATCH_CYC * CLK_NS);
    errors++;
    close_out();
  end

  initial
  begin
    ref_clk   = 1'b0;
    reset_n   = 1'b0;
    cmd_valid = 1'b0;
    cmd_op    = CMD_WRITE;
    cmd_data  = DATA_RESET;
    errors    = 0;
    n_checks  = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    chk_f("flags", 4'hC, lf());
    chk_w("data_out", DATA_RESET, lnk.data_out);
    foreach (rows[i])
    begin
      do_cmd(rows[i].op, rows[i].din);
      chk_b("rsp_error", rows[i].eexp, gerr);
      chk_f("flags", rows[i].fexp, lf());
      if ((rows[i].op == CMD_READ || rows[i].op == CMD_PEEK) && !rows[i].eexp)
        chk_w("rsp_data", rows[i].dexp, got);
    end
    // fill to full, then drain; flags tracked word by word
    for (int k = 0; k < 2 * FIFO_DEPTH; k++)
    begin
      do_cmd(k < FIFO_DEPTH ? CMD_WRITE : CMD_READ, WORD_W'(9'h100 + k % FIFO_DEPTH));
      occ = k < FIFO_DEPTH ? k + 1 : 2 * FIFO_DEPTH - 1 - k;
      chk_b("rsp_error", 1'b0, gerr);
      chk_f("flags", xf(occ, 2, 3), lf());
      chk_w("occupancy", WORD_W'(occ), WORD_W'(occupancy));
      if (k >= FIFO_DEPTH)
        chk_w("rsp_data", WORD_W'(9'h100 + k - FIFO_DEPTH), got);
      if (k == FIFO_DEPTH - 1)
      begin
        do_cmd(CMD_WRITE, 9'h1FF);
        chk_b("rsp_error", 1'b1, gerr);
        chk_f("flags", 4'h3, lf());
        do_cmd(CMD_REPLAY, 9'h000);
        chk_b("rsp_error", 1'b1, gerr);
      end
    end
    do_cmd(CMD_READ, 9'h000);
    chk_b("rsp_error", 1'b1, gerr);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_f("status", 4'hC, status);
    // master reset brings offsets and sequences back
    do_cmd(CMD_RESET, 9'h000);
    chk_f("flags", 4'hC, lf());
    chk_b("depth_mode", 1'b0, depth_mode);
    do_cmd(CMD_PEEK, 9'h000);
    chk_w("rsp_data", OFFS_DEFAULT_LOW, got);
    do_cmd(CMD_RESET, 9'h001);
    chk_b("depth_mode", 1'b1, depth_mode);
    // chained mode: load pin no longer opens the offsets
    do_cmd(CMD_PEEK, 9'h000);
    chk_w("rsp_data", DATA_RESET, got);
    chk_b("chain_token_out_n", 1'b1, lnk.chain_token_out_n);
    close_out();
  end
endmodule
